// ### core/ims_fifo.sv
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes: Full and empty follow an occupancy count.
`timescale 1ns/1ps
module ims_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
)
(
	// Clock, reset and freeze.
	input wire logic mclk,
	input wire logic rstn,
	input wire logic clkEn,
	// Fill side.
	input wire logic inVld,
	output logic inRdy,
	input wire logic [WIDTH-1:0] inData,
	// Drain side.
	output logic outVld,
	input wire logic outRdy,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [AW:0] count_q;
	wire push = inVld && inRdy;
	wire pop = outVld && outRdy;
	assign inRdy = (count_q != FULL);
	assign outVld = (count_q != '0);
	assign outData = mem[rdPtr_q];
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end
		else if (clkEn)
		begin
			wrPtr_q <= wrPtr_q + AW'(push);
			rdPtr_q <= rdPtr_q + AW'(pop);
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	always_ff @(posedge mclk)
	begin
		if (clkEn && push)
			mem[wrPtr_q] <= inData;
	end
endmodule : ims_fifo

// ### core/ims_pkg.sv
// Purpose: Shared constants and types for the two-wire master sequencer.
// Assumes: A 100 MHz system clock and a link bit period of 80 ns.
// Notes: Status codes keep their three low bits at zero.
package ims_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int LINK_PERIOD_NS = 80;
	localparam int QUARTER_NS = LINK_PERIOD_NS / 4;
	localparam int QUARTER_RAW = QUARTER_NS / CLK_PERIOD_NS;
	localparam logic [3:0] QUARTER_CYC = 4'((QUARTER_RAW < 1) ? 1 : QUARTER_RAW);
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_DATA = 8'h08;
	localparam logic [7:0] ADDR_RXFIFO = 8'h0C;
	localparam int CTRL_STEP = 0;
	localparam int CTRL_ACKEN = 1;
	localparam int CTRL_START = 2;
	localparam int CTRL_STOP = 3;
	localparam int CTRL_WCOL = 4;
	localparam int CTRL_ENABLE = 5;
	localparam int RX_VALID = 8;
	localparam logic [7:0] CODE_START = 8'h08;
	localparam logic [7:0] CODE_RSTART = 8'h10;
	localparam logic [7:0] CODE_AW_ACK = 8'h18;
	localparam logic [7:0] CODE_AW_NACK = 8'h20;
	localparam logic [7:0] CODE_DW_ACK = 8'h28;
	localparam logic [7:0] CODE_DW_NACK = 8'h30;
	localparam logic [7:0] CODE_ARB_LOST = 8'h38;
	localparam logic [7:0] CODE_AR_ACK = 8'h40;
	localparam logic [7:0] CODE_AR_NACK = 8'h48;
	localparam logic [7:0] CODE_DR_ACK = 8'h50;
	localparam logic [7:0] CODE_DR_NACK = 8'h58;
	localparam logic [7:0] CODE_RESET = 8'hF8;
	localparam logic [7:0] DATA_RESET = 8'hFF;
	localparam logic [1:0] PRESC_RESET = 2'h0;
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 8;
	typedef struct packed {
		logic enable;
		logic wcol;
		logic stopReq;
		logic startReq;
		logic ackEn;
	} ims_ctrl_t;
	localparam ims_ctrl_t CTRL_RESET = '0;
	typedef enum logic [2:0] {
		IMS_IDLE = 3'b000,
		IMS_WAITFREE = 3'b001,
		IMS_START = 3'b010,
		IMS_PAUSE = 3'b011,
		IMS_BIT = 3'b100,
		IMS_RSTART = 3'b101,
		IMS_STOP = 3'b110
	} ims_state_t;
endpackage : ims_pkg

// ### core/ims_sequencer.sv
// Purpose: Status-driven master sequencer for a byte-oriented two-wire bus, with an APB register slave.
// Assumes: Open-drain pins resolved outside; bus pins are asynchronous to mclk.
// Notes: Each START, repeated START or byte posts a status code and sets the step flag; the clock is held low except after arbitration loss.
`timescale 1ns/1ps
// Contract
// - Master mode only after own START; address direction bit picks transmit or receive.
// - Status codes read with prescaler bits in bits 1:0; software masks them.
// - After START report 0x08; cleared step with address sends it and samples ACK.
// - After repeated START report 0x10; read address switches to receive mode.
// - After write address report 0x18 on ACK, 0x20 on NACK.
// - After transmitted data byte report 0x28 on ACK, 0x30 on NACK.
// - In 0x18 to 0x30, clearing step with both requests low sends next byte.
// - Clearing step with start high and stop low sends repeated START.
// - Clearing step with stop high sends STOP; hardware clears stop request.
// - Both requests high send STOP then START; stop request cleared automatically.
// - Arbitration lost during write address or data reports 0x38.
// - In 0x38 with start low, release bus and become not-addressed slave.
// - In 0x38 with start high, wait for free bus then send START.
// - In receive mode, clock bytes in from the slave instead of out.
// - Transfer stays suspended while step flag is set; writing one clears it.
// - Data register writes while step flag clear are discarded and set collision.
module ims_sequencer
(
	// Clock, reset and freeze.
	input wire logic mclk,
	input wire logic rstn,
	input wire logic clkEn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Two-wire bus pins.
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe
);
	function automatic logic isAddrCode(input logic [7:0] code);
		isAddrCode = (code == ims_pkg::CODE_START) || (code == ims_pkg::CODE_RSTART);
	endfunction : isAddrCode

	function automatic logic isTxCode(input logic [7:0] code);
		isTxCode = (code == ims_pkg::CODE_AW_ACK) || (code == ims_pkg::CODE_AW_NACK) ||
			(code == ims_pkg::CODE_DW_ACK) || (code == ims_pkg::CODE_DW_NACK);
	endfunction : isTxCode

	ims_pkg::ims_state_t state_q, state_d;
	ims_pkg::ims_ctrl_t ctrl_q;
	logic [1:0] phase_q, phase_d;
	logic [3:0] bitCnt_q, bitCnt_d;
	logic [7:0] shift_q, shift_d;
	logic [7:0] code_q, code_d;
	logic [7:0] dataReg_q;
	logic [1:0] presc_q;
	logic [3:0] qCnt_q;
	logic [31:0] prdata_q;
	logic isAddr_q, isAddr_d;
	logic rxMode_q, rxMode_d;
	logic ackOk_q, ackOk_d;
	logic startAfter_q, startAfter_d;
	logic sclDrive_q, sclDrive_d;
	logic sdaDrive_q, sdaDrive_d;
	logic stepFlag_q;
	logic busBusy_q;
	logic post;
	logic hwClrStop;
	logic arbLost;
	logic [1:0] meta_q;
	logic [1:0] sync_q;
	logic [1:0] prev_q;

	// Each pin passes two flip-flops before anything looks at it.
	wire [1:0] pinIn = {sdaIn, sclIn};
	for (genvar i = 0; i < 2; i++)
	begin : g_sync
		always_ff @(posedge mclk or negedge rstn)
		begin
			if (!rstn)
			begin
				meta_q[i] <= 1'b1;
				sync_q[i] <= 1'b1;
				prev_q[i] <= 1'b1;
			end
			else if (clkEn)
			begin
				meta_q[i] <= pinIn[i];
				sync_q[i] <= meta_q[i];
				prev_q[i] <= sync_q[i];
			end
		end
	end

	wire sclHigh = sync_q[0];
	wire sdaHigh = sync_q[1];
	wire busStart = prev_q[1] && !sdaHigh && sclHigh && prev_q[0];
	wire busStop = !prev_q[1] && sdaHigh && sclHigh && prev_q[0];
	wire tick = (qCnt_q == 4'h1);

	// APB decode; zero wait states, read data captured in the setup cycle.
	wire setupPh = psel && !penable;
	wire accessPh = psel && penable && clkEn;
	wire hitCtrl = (paddr == ims_pkg::ADDR_CTRL);
	wire hitStatus = (paddr == ims_pkg::ADDR_STATUS);
	wire hitData = (paddr == ims_pkg::ADDR_DATA);
	wire hitRx = (paddr == ims_pkg::ADDR_RXFIFO);
	wire hitAny = hitCtrl || hitStatus || hitData || hitRx;
	wire wrCtrl = accessPh && pwrite && hitCtrl;
	wire wrStatus = accessPh && pwrite && hitStatus;
	wire wrData = accessPh && pwrite && hitData;
	wire stepClr = wrCtrl && pwdata[ims_pkg::CTRL_STEP] && stepFlag_q;
	wire dataOk = wrData && stepFlag_q;
	wire dataColl = wrData && !stepFlag_q;

	wire fifoInRdy;
	wire fifoOutVld;
	wire [7:0] fifoOutData;
	wire rxDone = (state_q == ims_pkg::IMS_BIT) && (phase_q == 2'd3) && (bitCnt_q == 4'd8);
	wire fifoPush = rxDone && tick && rxMode_q && !isAddr_q;
	// A full receive FIFO parks the ninth bit with the clock held low until software reads a word.
	wire rxStall = fifoPush && !fifoInRdy;
	wire fifoPop = accessPh && !pwrite && hitRx && fifoOutVld;
	wire [7:0] ctrlRd = {2'b00, ctrl_q.enable, ctrl_q.wcol, ctrl_q.stopReq, ctrl_q.startReq, ctrl_q.ackEn,
		stepFlag_q};
	wire [31:0] rdMux = hitCtrl ? {24'h00_0000, ctrlRd} :
		hitStatus ? {24'h00_0000, code_q[7:3], 1'b0, presc_q} :
		hitData ? {24'h00_0000, dataReg_q} :
		hitRx ? {23'h00_0000, fifoOutVld, fifoOutData} : 32'h0000_0000;

	assign pready = accessPh;
	assign pslverr = accessPh && !hitAny;
	assign prdata = prdata_q;
	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	assign sclOe = sclDrive_q;
	assign sdaOe = sdaDrive_q;

	ims_fifo #(
		.WIDTH(ims_pkg::FIFO_WIDTH),
		.DEPTH(ims_pkg::FIFO_DEPTH)
	) u_rxFifo (
		.mclk(mclk),
		.rstn(rstn),
		.clkEn(clkEn),
		.inVld(fifoPush),
		.inRdy(fifoInRdy),
		.inData(shift_q),
		.outVld(fifoOutVld),
		.outRdy(fifoPop),
		.outData(fifoOutData)
	);

	// Sequencer: every phase lasts one quarter of a bit; phase 2 of a bit, repeated START or STOP also waits for the released clock line.
	always_comb
	begin
		state_d = state_q;
		phase_d = phase_q;
		bitCnt_d = bitCnt_q;
		shift_d = shift_q;
		code_d = code_q;
		isAddr_d = isAddr_q;
		rxMode_d = rxMode_q;
		ackOk_d = ackOk_q;
		startAfter_d = startAfter_q;
		sclDrive_d = sclDrive_q;
		sdaDrive_d = sdaDrive_q;
		post = 1'b0;
		hwClrStop = 1'b0;
		arbLost = 1'b0;
		unique case (state_q)
			ims_pkg::IMS_IDLE:
			begin
				sclDrive_d = 1'b0;
				sdaDrive_d = 1'b0;
				if (ctrl_q.enable && ctrl_q.startReq)
					state_d = ims_pkg::IMS_WAITFREE;
			end
			ims_pkg::IMS_WAITFREE:
			begin
				if (tick && !busBusy_q && sclHigh && sdaHigh)
				begin
					state_d = ims_pkg::IMS_START;
					phase_d = 2'd0;
				end
			end
			ims_pkg::IMS_START:
			begin
				if (tick)
				begin
					phase_d = phase_q + 2'd1;
					if (phase_q == 2'd0)
						sdaDrive_d = 1'b1;
					else
					begin
						sclDrive_d = 1'b1;
						code_d = ims_pkg::CODE_START;
						post = 1'b1;
						state_d = ims_pkg::IMS_PAUSE;
					end
				end
			end
			ims_pkg::IMS_RSTART, ims_pkg::IMS_STOP:
			begin
				if (tick && (phase_q != 2'd2 || sclHigh))
				begin
					phase_d = phase_q + 2'd1;
					unique case (phase_q)
						2'd0:
						begin
							sclDrive_d = 1'b1;
							sdaDrive_d = (state_q == ims_pkg::IMS_STOP);
						end
						2'd1: sclDrive_d = 1'b0;
						2'd2: sdaDrive_d = (state_q == ims_pkg::IMS_RSTART);
						2'd3:
						begin
							if (state_q == ims_pkg::IMS_RSTART)
							begin
								sclDrive_d = 1'b1;
								code_d = ims_pkg::CODE_RSTART;
								post = 1'b1;
								state_d = ims_pkg::IMS_PAUSE;
							end
							else
								state_d = startAfter_q ? ims_pkg::IMS_WAITFREE : ims_pkg::IMS_IDLE;
						end
					endcase
				end
			end
			ims_pkg::IMS_BIT:
			begin
				if (tick && (phase_q != 2'd2 || sclHigh))
				begin
					phase_d = phase_q + 2'd1;
					unique case (phase_q)
						2'd0:
						begin
							sclDrive_d = 1'b1;
							if (bitCnt_q != 4'd8)
								sdaDrive_d = !shift_q[7] && (!rxMode_q || isAddr_q);
							else
								sdaDrive_d = rxMode_q && !isAddr_q && ctrl_q.ackEn;
						end
						2'd1: sclDrive_d = 1'b0;
						2'd2:
						begin
							if (bitCnt_q == 4'd8)
								ackOk_d = !sdaHigh;
							else if (!sdaDrive_q && !sdaHigh && (!rxMode_q || isAddr_q))
								arbLost = 1'b1;
							else
								shift_d = {shift_q[6:0], sdaHigh};
						end
						2'd3:
						begin
							sclDrive_d = 1'b1;
							if (rxStall)
								phase_d = phase_q;
							else
								bitCnt_d = bitCnt_q + 4'd1;
							if (bitCnt_q == 4'd8 && !rxStall)
							begin
								post = 1'b1;
								state_d = ims_pkg::IMS_PAUSE;
								if (isAddr_q)
									code_d = rxMode_q ? (ackOk_q ? ims_pkg::CODE_AR_ACK : ims_pkg::CODE_AR_NACK) :
										(ackOk_q ? ims_pkg::CODE_AW_ACK : ims_pkg::CODE_AW_NACK);
								else
									code_d = rxMode_q ? (ackOk_q ? ims_pkg::CODE_DR_ACK : ims_pkg::CODE_DR_NACK) :
										(ackOk_q ? ims_pkg::CODE_DW_ACK : ims_pkg::CODE_DW_NACK);
							end
						end
					endcase
					if (arbLost)
					begin
						sclDrive_d = 1'b0;
						sdaDrive_d = 1'b0;
						code_d = ims_pkg::CODE_ARB_LOST;
						post = 1'b1;
						state_d = ims_pkg::IMS_PAUSE;
					end
				end
			end
			ims_pkg::IMS_PAUSE:
			begin
				if (!stepFlag_q)
				begin
					phase_d = 2'd0;
					bitCnt_d = 4'd0;
					if (code_q == ims_pkg::CODE_ARB_LOST)
					begin
						sclDrive_d = 1'b0;
						sdaDrive_d = 1'b0;
						state_d = ctrl_q.startReq ? ims_pkg::IMS_WAITFREE : ims_pkg::IMS_IDLE;
					end
					else if (ctrl_q.stopReq)
					begin
						hwClrStop = 1'b1;
						startAfter_d = ctrl_q.startReq;
						state_d = ims_pkg::IMS_STOP;
					end
					else if (ctrl_q.startReq)
						state_d = ims_pkg::IMS_RSTART;
					else
					begin
						state_d = ims_pkg::IMS_BIT;
						isAddr_d = isAddrCode(code_q);
						if (isAddrCode(code_q))
							rxMode_d = dataReg_q[0];
						shift_d = (rxMode_q && !isAddrCode(code_q)) ? ims_pkg::DATA_RESET : dataReg_q;
					end
				end
			end
			default: state_d = ims_pkg::IMS_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= ims_pkg::IMS_IDLE;
			phase_q <= 2'd0;
			bitCnt_q <= 4'd0;
			shift_q <= ims_pkg::DATA_RESET;
			code_q <= ims_pkg::CODE_RESET;
			isAddr_q <= 1'b0;
			rxMode_q <= 1'b0;
			ackOk_q <= 1'b0;
			startAfter_q <= 1'b0;
			sclDrive_q <= 1'b0;
			sdaDrive_q <= 1'b0;
		end
		else if (clkEn)
		begin
			state_q <= state_d;
			phase_q <= phase_d;
			bitCnt_q <= bitCnt_d;
			shift_q <= shift_d;
			code_q <= code_d;
			isAddr_q <= isAddr_d;
			rxMode_q <= rxMode_d;
			ackOk_q <= ackOk_d;
			startAfter_q <= startAfter_d;
			sclDrive_q <= sclDrive_d;
			sdaDrive_q <= sdaDrive_d;
		end
	end

	// Quarter-bit timer and bus-busy tracker.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			qCnt_q <= ims_pkg::QUARTER_CYC;
			busBusy_q <= 1'b0;
		end
		else if (clkEn)
		begin
			qCnt_q <= tick ? ims_pkg::QUARTER_CYC : qCnt_q - 4'd1;
			if (busStart)
				busBusy_q <= 1'b1;
			else if (busStop)
				busBusy_q <= 1'b0;
		end
	end

	// Registers; a hardware set of the step and collision flags wins over a software clear.
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_q <= ims_pkg::CTRL_RESET;
			stepFlag_q <= 1'b0;
			dataReg_q <= ims_pkg::DATA_RESET;
			presc_q <= ims_pkg::PRESC_RESET;
			prdata_q <= 32'h0000_0000;
		end
		else if (clkEn)
		begin
			stepFlag_q <= post || (stepFlag_q && !stepClr);
			if (wrCtrl)
			begin
				ctrl_q.enable <= pwdata[ims_pkg::CTRL_ENABLE];
				ctrl_q.stopReq <= pwdata[ims_pkg::CTRL_STOP];
				ctrl_q.startReq <= pwdata[ims_pkg::CTRL_START];
				ctrl_q.ackEn <= pwdata[ims_pkg::CTRL_ACKEN];
			end
			else if (hwClrStop)
				ctrl_q.stopReq <= 1'b0;
			ctrl_q.wcol <= dataColl || (ctrl_q.wcol && !(wrCtrl && pwdata[ims_pkg::CTRL_WCOL]));
			if (dataOk)
				dataReg_q <= pwdata[7:0];
			else if (fifoPush && fifoInRdy)
				dataReg_q <= shift_q;
			if (wrStatus)
				presc_q <= pwdata[1:0];
			if (setupPh)
				prdata_q <= rdMux;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	startThenCode_a: assert property (clkEn && post && code_d == ims_pkg::CODE_START |-> state_q == ims_pkg::IMS_START)
		else $error("start status posted without a start");
	lowBitsZero_a: assert property (code_q[2:0] == 3'b000)
		else $error("status code has nonzero low bits");
	addrSent_a: assert property (clkEn && state_q == ims_pkg::IMS_PAUSE && !stepFlag_q && isAddrCode(code_q) &&
		!ctrl_q.startReq && !ctrl_q.stopReq |=> state_q == ims_pkg::IMS_BIT && isAddr_q && shift_q == $past(dataReg_q))
		else $error("address not sent after step clear");
	addrCode_a: assert property (clkEn && post && isAddr_q && !rxMode_q && state_q == ims_pkg::IMS_BIT && !arbLost
		|=> code_q == (ackOk_q ? ims_pkg::CODE_AW_ACK : ims_pkg::CODE_AW_NACK))
		else $error("wrong address write status");
	repStart_a: assert property (clkEn && state_q == ims_pkg::IMS_PAUSE && !stepFlag_q && isTxCode(code_q) &&
		ctrl_q.startReq && !ctrl_q.stopReq |=> state_q == ims_pkg::IMS_RSTART)
		else $error("repeated start not taken");
	stopClears_a: assert property (clkEn && state_q == ims_pkg::IMS_PAUSE && !stepFlag_q && !wrCtrl &&
		code_q != ims_pkg::CODE_ARB_LOST && ctrl_q.stopReq |=> state_q == ims_pkg::IMS_STOP && !ctrl_q.stopReq)
		else $error("stop not taken or request not cleared");
	arbCode_a: assert property (clkEn && arbLost |=> code_q == ims_pkg::CODE_ARB_LOST && stepFlag_q && !sclOe && !sdaOe)
		else $error("arbitration loss not reported");
	holdPause_a: assert property (clkEn && stepFlag_q && state_q == ims_pkg::IMS_PAUSE && !stepClr
		|=> state_q == ims_pkg::IMS_PAUSE && $stable(sclOe))
		else $error("transfer moved while step flag set");
	collision_a: assert property (clkEn && dataColl |=> ctrl_q.wcol && $stable(dataReg_q))
		else $error("late data write not discarded");
endmodule : ims_sequencer

// ### dv/ims_slave_model.sv
// Purpose: Behavioural slave receiver and transmitter on the two-wire bus, with a competing master option.
// Assumes: Both lines are pulled up outside; this model only ever pulls sda low.
// Notes: Read mode sends txByte first, then one more for every byte after it.
`timescale 1ns/1ps
module ims_slave_model
(
	// Bus lines.
	input wire logic scl,
	input wire logic sda,
	output logic sdaOe,
	// Controls.
	input wire logic nackAddr,
	input wire logic nackData,
	input wire logic arbLose,
	input wire logic [7:0] txByte,
	// Observation.
	output logic [7:0] lastByte,
	output int byteCount,
	output int stopCount
);
	logic [7:0] shiftQ = 8'h00;
	logic [7:0] cur = 8'h00;
	logic inFrame = 1'b0;
	logic isAddr = 1'b0;
	logic reading = 1'b0;
	logic ackd = 1'b0;
	int bitN = 0;
	initial
	begin
		sdaOe = 1'b0;
		lastByte = 8'h00;
		byteCount = 0;
		stopCount = 0;
	end
	// A fall of sda while scl is high opens a frame.
	always @(negedge sda)
	begin
		if (scl)
		begin
			inFrame = 1'b1;
			isAddr = 1'b1;
			reading = 1'b0;
			bitN = 0;
		end
	end
	always @(posedge sda)
	begin
		if (scl && inFrame)
		begin
			inFrame = 1'b0;
			stopCount++;
		end
	end
	// The competing master lets go when arbLose falls, which the bus sees as a STOP.
	always @(negedge arbLose)
		sdaOe = 1'b0;
	always @(posedge scl)
	begin
		if (inFrame && bitN < 8)
			shiftQ = {shiftQ[6:0], sda};
		if (inFrame && bitN == 8)
			ackd = !sda;
		bitN++;
	end
	always @(negedge scl)
	begin
		if (inFrame && bitN == 8)
		begin
			lastByte = shiftQ;
			byteCount++;
			if (isAddr)
				reading = shiftQ[0];
			if (isAddr)
				cur = txByte;
			sdaOe = (isAddr || !reading) && !(isAddr ? nackAddr : nackData);
		end
		else if (inFrame && bitN == 9)
		begin
			if (!isAddr && reading)
				cur = cur + 8'h01;
			reading = reading && (isAddr || ackd);
			isAddr = 1'b0;
			bitN = 0;
			sdaOe = reading && !cur[7];
		end
		else if (inFrame)
			sdaOe = reading ? !cur[7 - bitN] : (arbLose && isAddr);
	end
endmodule : ims_slave_model

// ### dv/testbench.sv
// Purpose: Self-checking bench for the two-wire master sequencer over APB.
// Assumes: Open-drain lines resolved here with pull-ups; clkEn held high.
// Notes: Random bytes and addresses from a fixed seed, corner cases by hand.
`timescale 1ns/1ps
module testbench;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic clkEn = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sclOe;
	logic sdaOe;
	logic slvSdaOe;
	logic nackAddr = 1'b0;
	logic nackData = 1'b0;
	logic arbLose = 1'b0;
	logic [7:0] txByte = 8'h00;
	logic [7:0] lastByte;
	int byteCount;
	int stopCount;
	int bad_count = 0;
	int checked = 0;
	int cycles = 0;
	int s;
	logic [31:0] rd;
	logic lastErr;
	logic [7:0] aw;
	wire scl = !sclOe;
	wire sda = !(sdaOe || slvSdaOe);
	always #5 mclk = !mclk;
	ims_sequencer ims_sequencer_i (.mclk(mclk), .rstn(rstn), .clkEn(clkEn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sclIn(scl), .sclOut(), .sclOe(sclOe), .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe));
	ims_slave_model ims_slave_model_i (.scl(scl), .sda(sda), .sdaOe(slvSdaOe), .nackAddr(nackAddr),
		.nackData(nackData), .arbLose(arbLose), .txByte(txByte), .lastByte(lastByte), .byteCount(byteCount),
		.stopCount(stopCount));
	task automatic results();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			bad_count++;
			results();
		end
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		rd = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : bus
	function automatic logic [31:0] ctl(input logic start_request, input logic stop_request, input logic ack);
		ctl = 32'h0000_0000;
		ctl[ims_pkg::CTRL_ENABLE] = 1'b1;
		ctl[ims_pkg::CTRL_STEP] = 1'b1;
		ctl[ims_pkg::CTRL_START] = start_request;
		ctl[ims_pkg::CTRL_STOP] = stop_request;
		ctl[ims_pkg::CTRL_ACKEN] = ack;
	endfunction : ctl
	function automatic logic [31:0] rxWord(input int k);
		rxWord = {23'h00_0000, 1'b1, 8'(txByte + k)};
	endfunction : rxWord
	task automatic act(input logic [31:0] c, input logic [7:0] code);
		bus(1'b1, ims_pkg::ADDR_CTRL, c);
		do
			bus(1'b0, ims_pkg::ADDR_CTRL, 32'h0000_0000);
		while (rd[ims_pkg::CTRL_STEP] !== 1'b1);
		bus(1'b0, ims_pkg::ADDR_STATUS, 32'h0000_0000);
		cmp(rd & 32'h0000_00F8, {24'h00_0000, code});
	endtask : act
	task automatic send(input logic [7:0] b, input logic [7:0] code);
		bus(1'b1, ims_pkg::ADDR_DATA, {24'h00_0000, b});
		act(ctl(1'b0, 1'b0, 1'($urandom)), code);
		cmp({24'h00_0000, lastByte}, {24'h00_0000, b});
	endtask : send
	task automatic stopSeen(input int s0);
		do
			bus(1'b0, ims_pkg::ADDR_CTRL, 32'h0000_0000);
		while (rd[ims_pkg::CTRL_STOP] !== 1'b0);
		for (int k = 0; k < 200 && stopCount == s0; k++)
			@(posedge mclk);
		cmp(stopCount, s0 + 1);
	endtask : stopSeen
	initial
	begin
		void'($urandom(32'hd302_1f4d));
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		bus(1'b0, ims_pkg::ADDR_STATUS, 32'h0000_0000);
		cmp(rd, {24'h00_0000, ims_pkg::CODE_RESET});
		bus(1'b0, ims_pkg::ADDR_DATA, 32'h0000_0000);
		cmp(rd, {24'h00_0000, ims_pkg::DATA_RESET});
		bus(1'b0, 8'h10, 32'h0000_0000);
		cmp({rd[30:0], lastErr}, 32'h0000_0001);
		cmp({30'h0000_0000, sclOe, sdaOe}, 32'h0000_0000);
		bus(1'b1, ims_pkg::ADDR_DATA, 32'h0000_005A);
		bus(1'b0, ims_pkg::ADDR_CTRL, 32'h0000_0000);
		cmp(rd, 32'h0000_0010);
		bus(1'b0, ims_pkg::ADDR_DATA, 32'h0000_0000);
		cmp(rd, {24'h00_0000, ims_pkg::DATA_RESET});
		bus(1'b1, ims_pkg::ADDR_CTRL, 32'h0000_0010);
		bus(1'b1, ims_pkg::ADDR_STATUS, 32'h0000_0003);
		bus(1'b0, ims_pkg::ADDR_STATUS, 32'h0000_0000);
		cmp(rd, 32'h0000_00FB);
		act(ctl(1'b1, 1'b0, 1'b0), ims_pkg::CODE_START);
		s = byteCount;
		repeat (60) @(posedge mclk);
		cmp({sclOe, 31'(byteCount - s)}, 32'h8000_0000);
		aw = {7'($urandom), 1'b0};
		send(aw, ims_pkg::CODE_AW_ACK);
		repeat (3) send(8'($urandom), ims_pkg::CODE_DW_ACK);
		nackData <= 1'b1;
		send(8'($urandom), ims_pkg::CODE_DW_NACK);
		nackData <= 1'b0;
		send(8'($urandom), ims_pkg::CODE_DW_ACK);
		act(ctl(1'b1, 1'b0, 1'b0), ims_pkg::CODE_RSTART);
		nackAddr <= 1'b1;
		send(aw, ims_pkg::CODE_AW_NACK);
		nackAddr <= 1'b0;
		send(8'($urandom), ims_pkg::CODE_DW_ACK);
		s = stopCount;
		bus(1'b1, ims_pkg::ADDR_CTRL, ctl(1'b0, 1'b1, 1'b0));
		stopSeen(s);
		cmp({30'h0000_0000, sclOe, sdaOe}, 32'h0000_0000);
		act(ctl(1'b1, 1'b0, 1'b0), ims_pkg::CODE_START);
		send(aw, ims_pkg::CODE_AW_ACK);
		s = stopCount;
		act(ctl(1'b1, 1'b1, 1'b0), ims_pkg::CODE_START);
		stopSeen(s);
		arbLose <= 1'b1;
		bus(1'b1, ims_pkg::ADDR_DATA, {24'h00_0000, aw | 8'hC0});
		act(ctl(1'b0, 1'b0, 1'b0), ims_pkg::CODE_ARB_LOST);
		arbLose <= 1'b0;
		act(ctl(1'b1, 1'b0, 1'b0), ims_pkg::CODE_START);
		arbLose <= 1'b1;
		s = byteCount;
		bus(1'b1, ims_pkg::ADDR_DATA, 32'h0000_00C0);
		act(ctl(1'b0, 1'b0, 1'b0), ims_pkg::CODE_ARB_LOST);
		cmp(32'(byteCount - s), 32'h0000_0000);
		arbLose <= 1'b0;
		bus(1'b1, ims_pkg::ADDR_CTRL, ctl(1'b0, 1'b0, 1'b0));
		repeat (60) @(posedge mclk);
		bus(1'b0, ims_pkg::ADDR_CTRL, 32'h0000_0000);
		cmp({sclOe, sdaOe, 29'h0000_0000, rd[ims_pkg::CTRL_STEP]}, 32'h0000_0000);
		act(ctl(1'b1, 1'b0, 1'b0), ims_pkg::CODE_START);
		send(aw, ims_pkg::CODE_AW_ACK);
		act(ctl(1'b1, 1'b0, 1'b0), ims_pkg::CODE_RSTART);
		txByte <= 8'($urandom);
		send(aw | 8'h01, ims_pkg::CODE_AR_ACK);
		repeat (8) act(ctl(1'b0, 1'b0, 1'b1), ims_pkg::CODE_DR_ACK);
		bus(1'b1, ims_pkg::ADDR_CTRL, ctl(1'b0, 1'b0, 1'b0));
		repeat (150) @(posedge mclk);
		bus(1'b0, ims_pkg::ADDR_CTRL, 32'h0000_0000);
		cmp({sclOe, 30'h0000_0000, rd[ims_pkg::CTRL_STEP]}, 32'h8000_0000);
		bus(1'b0, ims_pkg::ADDR_RXFIFO, 32'h0000_0000);
		cmp(rd, rxWord(0));
		act(32'h0000_0000, ims_pkg::CODE_DR_NACK);
		for (int k = 1; k < 9; k++)
		begin
			bus(1'b0, ims_pkg::ADDR_RXFIFO, 32'h0000_0000);
			cmp(rd, rxWord(k));
		end
		bus(1'b0, ims_pkg::ADDR_RXFIFO, 32'h0000_0000);
		cmp({31'h0000_0000, rd[ims_pkg::RX_VALID]}, 32'h0000_0000);
		s = stopCount;
		bus(1'b1, ims_pkg::ADDR_CTRL, ctl(1'b0, 1'b1, 1'b0));
		stopSeen(s);
		results();
	end
endmodule : testbench
